// file: dv/tb.sv
// self-checking bench for the condition flag unit
`timescale 1ns/1ps
module tb import cfl_pkg::*; ;
  logic       clk, rst_n, alu_go, status_load, restart_go, carry_model;
  logic       zero_flag, sign_flag, parity_flag, carry_out_flag, nibble_carry_flag;
  cfl_op_t    alu_op;
  cfl_ptr_t   prog_counter_cmd, stack_ptr_cmd;
  logic [7:0] alu_a, alu_b, status_in, port_byte, alu_result, processor_status_word;
  logic [7:0] src_onehot, dst_onehot, io_port_addr;
  logic [7:0] program_counter_high, program_counter_low, stack_pointer_high, stack_pointer_low;
  logic [2:0] source_register_field, dest_register_field, restart_number_field;
  logic [15:0] ptr_in;
  int         fails, checked;
  cfl_flag_unit DUT (.clk, .rst_n, .alu_go, .alu_op, .alu_a, .alu_b, .status_load, .status_in,
    .source_register_field, .dest_register_field, .prog_counter_cmd, .stack_ptr_cmd, .ptr_in,
    .restart_go,
    .restart_number_field, .port_byte, .alu_result, .zero_flag, .sign_flag, .parity_flag,
    .carry_out_flag, .nibble_carry_flag, .processor_status_word, .src_onehot, .dst_onehot,
    .program_counter_high, .program_counter_low, .stack_pointer_high, .stack_pointer_low,
    .io_port_addr);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one edge to take the request, then settle to mid-cycle
  task step;
    @(posedge clk);
    {alu_go, status_load, restart_go} <= 3'h0;
    prog_counter_cmd <= CFL_PTR_HOLD;
    stack_ptr_cmd    <= CFL_PTR_HOLD;
    @(negedge clk);
  endtask : step
  function automatic logic [7:0] pw(logic [7:0] r, logic c, logic ac);
    return {r[7], r == 8'h00, 1'b0, ac, 1'b0, ~^r, 1'b1, c};
  endfunction : pw
  task alu(input cfl_op_t op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] prev;
    logic       ci;
    ci = (op == CFL_OP_ADC || op == CFL_OP_SBB) ? carry_model : 1'b0;
    prev = alu_result;
    case (op)
      CFL_OP_ADD, CFL_OP_ADC: begin
        s = a + b + ci;
        n = a[3:0] + b[3:0] + ci;
      end
      CFL_OP_AND: begin s = {1'b0, a & b}; n = 5'h0; end
      CFL_OP_XOR: begin s = {1'b0, a ^ b}; n = 5'h0; end
      CFL_OP_OR:  begin s = {1'b0, a | b}; n = 5'h0; end
      default: begin
        s = {1'b0, a} - b - ci;
        n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~ci};
      end
    endcase
    @(posedge clk);
    {alu_go, alu_op, alu_a, alu_b} <= {1'b1, op, a, b};
    step;
    carry_model = s[8];
    chk({8'h0, processor_status_word}, {8'h0, pw(s[7:0], s[8], n[4])});
    chk({11'h0, sign_flag, zero_flag, parity_flag, carry_out_flag, nibble_carry_flag},
        {11'h0, s[7], s[7:0] == 8'h00, ~^s[7:0], s[8], n[4]});
    chk({8'h0, alu_result}, {8'h0, (op == CFL_OP_CMP) ? prev : s[7:0]});
  endtask : alu
  ////////////////////////////////////////////////////////////////////////////////
  task t_alu;
    alu(CFL_OP_ADD, 8'hff, 8'h01);
    alu(CFL_OP_ADC, 8'h0f, 8'h00);
    alu(CFL_OP_SUB, 8'h00, 8'h01);
    alu(CFL_OP_SBB, 8'h10, 8'h0f);
    alu(CFL_OP_AND, 8'hf3, 8'h81);
    alu(CFL_OP_XOR, 8'haa, 8'h55);
    alu(CFL_OP_OR,  8'h00, 8'h00);
    alu(CFL_OP_CMP, 8'h05, 8'h06);
    alu(CFL_OP_CMP, 8'h77, 8'h77);
    $display("test alu done");
  endtask : t_alu
  task t_psw;
    @(posedge clk);
    {status_load, status_in, alu_go, alu_op} <= {1'b1, 8'hff, 1'b1, CFL_OP_XOR};
    {alu_a, alu_b} <= {8'h0f, 8'h00};
    step;
    chk({8'h0, processor_status_word}, 16'h00d7);
    chk({8'h0, alu_result}, 16'h0000);
    repeat (3) step;
    chk({8'h0, processor_status_word}, 16'h00d7);
    carry_model = 1'b1;
    $display("test psw done");
  endtask : t_psw
  task t_reg;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      source_register_field <= i[2:0];
      dest_register_field   <= 3'h7 - i[2:0];
      step;
      chk({8'h0, src_onehot}, (i == 6) ? 16'h0 : 16'h1 << i);
      chk({8'h0, dst_onehot}, (i == 1) ? 16'h0 : 16'h1 << (7 - i));
    end
    $display("test reg done");
  endtask : t_reg
  task t_ptr;
    @(posedge clk);
    {prog_counter_cmd, stack_ptr_cmd, ptr_in} <= {CFL_PTR_LOAD, CFL_PTR_LOAD, 16'h1234};
    step;
    chk({program_counter_high, program_counter_low}, 16'h1234);
    chk({stack_pointer_high, stack_pointer_low}, 16'h1234);
    @(posedge clk);
    {prog_counter_cmd, stack_ptr_cmd, ptr_in} <= {CFL_PTR_LOAD_HI, CFL_PTR_LOAD_LO, 16'h00ab};
    step;
    chk({program_counter_high, program_counter_low}, 16'hab34);
    chk({stack_pointer_high, stack_pointer_low}, 16'h12ab);
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      {restart_go, restart_number_field, prog_counter_cmd, ptr_in} <=
        {1'b1, n[2:0], CFL_PTR_LOAD, 16'hffff};
      step;
      chk({program_counter_high, program_counter_low}, {10'h0, n[2:0], 3'h0});
    end
    $display("test ptr done");
  endtask : t_ptr
  task t_io;
    @(posedge clk);
    port_byte <= 8'ha5;
    step;
    chk({8'h0, io_port_addr}, 16'h00a5);
    $display("test io done");
  endtask : t_io
  task end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    end_of_test;
  end
  initial begin
    {rst_n, alu_go, status_load, restart_go, alu_a, alu_b, status_in, port_byte} = '0;
    {source_register_field, dest_register_field, restart_number_field, ptr_in} = '0;
    {alu_op, prog_counter_cmd, stack_ptr_cmd, carry_model} =
      {CFL_OP_ADD, CFL_PTR_HOLD, CFL_PTR_HOLD, 1'b0};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({8'h0, processor_status_word}, 16'h0002);
    t_alu;
    t_psw;
    t_reg;
    t_ptr;
    t_io;
    end_of_test;
  end
endmodule : tb

// file: verilog/cfl_flag_unit.sv
// condition flag alu, register decode, pointer byte access and operand encodings
`timescale 1ns/1ps
module cfl_flag_unit import cfl_pkg::*; (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          alu_go,
  input  cfl_op_t            alu_op,
  input  wire logic [DW-1:0] alu_a,
  input  wire logic [DW-1:0] alu_b,
  input  wire logic          status_load,
  input  wire logic [DW-1:0] status_in,
  input  wire logic [2:0]    source_register_field,
  input  wire logic [2:0]    dest_register_field,
  input  cfl_ptr_t           prog_counter_cmd,
  input  cfl_ptr_t           stack_ptr_cmd,
  input  wire logic [AW-1:0] ptr_in,
  input  wire logic          restart_go,
  input  wire logic [2:0]    restart_number_field,
  input  wire logic [DW-1:0] port_byte,
  output logic [DW-1:0]      alu_result,
  output logic               zero_flag,
  output logic               sign_flag,
  output logic               parity_flag,
  output logic               carry_out_flag,
  output logic               nibble_carry_flag,
  output logic [DW-1:0]      processor_status_word,
  output logic [7:0]         src_onehot,
  output logic [7:0]         dst_onehot,
  output logic [DW-1:0]      program_counter_high,
  output logic [DW-1:0]      program_counter_low,
  output logic [DW-1:0]      stack_pointer_high,
  output logic [DW-1:0]      stack_pointer_low,
  output logic [DW-1:0]      io_port_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic
  logic [DW:0]   sum;
  logic [NIB:0]  nsum;
  logic [DW-1:0] res;
  logic          is_sub;
  logic          cin;
  logic          arith;
  logic [DW-1:0] bop;

  always_comb begin
    is_sub = (alu_op == CFL_OP_SUB) || (alu_op == CFL_OP_SBB) || (alu_op == CFL_OP_CMP);
    cin    = ((alu_op == CFL_OP_ADC) || (alu_op == CFL_OP_SBB)) ? carry_out_flag : 1'b0;
    arith  = !((alu_op == CFL_OP_AND) || (alu_op == CFL_OP_XOR) || (alu_op == CFL_OP_OR));
    bop    = is_sub ? ~alu_b : alu_b;
    // subtract as a + ~b + 1 - borrow_in; carry out inverted gives borrow
    sum    = {1'b0, alu_a} + {1'b0, bop} + {{DW{1'b0}}, (is_sub ? ~cin : cin)};
    nsum   = {1'b0, alu_a[NIB-1:0]} + {1'b0, bop[NIB-1:0]} +
             {{NIB{1'b0}}, (is_sub ? ~cin : cin)};
    case (alu_op)
      CFL_OP_AND: res = alu_a & alu_b;
      CFL_OP_XOR: res = alu_a ^ alu_b;
      CFL_OP_OR:  res = alu_a | alu_b;
      default:    res = sum[DW-1:0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_flag         <= 1'b0;
      sign_flag         <= 1'b0;
      parity_flag       <= 1'b0;
      carry_out_flag    <= 1'b0;
      nibble_carry_flag <= 1'b0;
    end else if (status_load) begin
      carry_out_flag    <= status_in[FLAG_CARRY_BIT];
      parity_flag       <= status_in[FLAG_PAR_BIT];
      nibble_carry_flag <= status_in[FLAG_NIB_BIT];
      zero_flag         <= status_in[FLAG_ZERO_BIT];
      sign_flag         <= status_in[FLAG_SIGN_BIT];
    end else if (alu_go) begin
      zero_flag         <= (res == '0);
      sign_flag         <= res[DW-1];
      parity_flag       <= ~^res;
      carry_out_flag    <= arith ? (sum[DW] ^ is_sub) : 1'b0;
      nibble_carry_flag <= arith ? nsum[NIB] : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) alu_result <= '0;
    // a status load wins over the alu, so the result must hold as well
    else if (alu_go && !status_load && alu_op != CFL_OP_CMP) alu_result <= res;
  end

  always_comb begin
    processor_status_word          = '0;
    processor_status_word[FLAG_CARRY_BIT] = carry_out_flag;
    processor_status_word[FLAG_ONE_BIT]   = 1'b1;
    processor_status_word[FLAG_PAR_BIT]   = parity_flag;
    processor_status_word[FLAG_NIB_BIT]   = nibble_carry_flag;
    processor_status_word[FLAG_ZERO_BIT]  = zero_flag;
    processor_status_word[FLAG_SIGN_BIT]  = sign_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register field decode, code 110 selects no register
  for (genvar i = 0; i < 8; i++) begin : g_dec
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        src_onehot[i] <= 1'b0;
        dst_onehot[i] <= 1'b0;
      end else begin
        src_onehot[i] <= (source_register_field == 3'(i)) && (3'(i) != RSEL_M);
        dst_onehot[i] <= (dest_register_field == 3'(i)) && (3'(i) != RSEL_M);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointers
  logic [AW-1:0] prog_counter_q;
  logic [AW-1:0] stack_ptr_q;
  assign program_counter_high = prog_counter_q[AW-1:DW];
  assign program_counter_low  = prog_counter_q[DW-1:0];
  assign stack_pointer_high   = stack_ptr_q[AW-1:DW];
  assign stack_pointer_low    = stack_ptr_q[DW-1:0];

  // a restart overrides any program counter load issued in the same cycle; stack pointer loads still happen
  always_ff @(posedge clk) begin
    if (!rst_n) prog_counter_q <= '0;
    else if (restart_go)
      prog_counter_q <= {{(AW-6){1'b0}}, restart_number_field, RST_SHIFT'(3'h0)};
    else case (prog_counter_cmd)
      CFL_PTR_LOAD_HI: prog_counter_q[AW-1:DW] <= ptr_in[DW-1:0];
      CFL_PTR_LOAD_LO: prog_counter_q[DW-1:0]  <= ptr_in[DW-1:0];
      CFL_PTR_LOAD:    prog_counter_q          <= ptr_in;
      default:         prog_counter_q          <= prog_counter_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) stack_ptr_q <= '0;
    else case (stack_ptr_cmd)
      CFL_PTR_LOAD_HI: stack_ptr_q[AW-1:DW] <= ptr_in[DW-1:0];
      CFL_PTR_LOAD_LO: stack_ptr_q[DW-1:0]  <= ptr_in[DW-1:0];
      CFL_PTR_LOAD:    stack_ptr_q          <= ptr_in;
      default:         stack_ptr_q          <= stack_ptr_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) io_port_addr <= '0;
    else io_port_addr <= port_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !alu_go && !status_load |=> $stable(processor_status_word))
    else $error("flags changed without update");
  a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load |=> zero_flag == (alu_result == '0) || $past(alu_op) == CFL_OP_CMP)
    else $error("zero flag wrong");
  a_sign_flag: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && alu_op != CFL_OP_CMP |=> sign_flag == alu_result[DW-1])
    else $error("sign flag wrong");
  a_parity_flag: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && alu_op != CFL_OP_CMP |=> parity_flag == ~^alu_result)
    else $error("parity flag wrong");
  a_carry_add: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && alu_op == CFL_OP_ADD
    |=> carry_out_flag == ({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} > 9'h0ff))
    else $error("add carry wrong");
  a_borrow_cmp: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && alu_op == CFL_OP_CMP
    |=> carry_out_flag == ($past(alu_a) < $past(alu_b)))
    else $error("compare borrow wrong");
  a_borrow_sub: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && alu_op == CFL_OP_SUB
    |=> carry_out_flag == ($past(alu_a) < $past(alu_b)))
    else $error("subtract borrow wrong");
  a_borrow_sbb: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && alu_op == CFL_OP_SBB
    |=> carry_out_flag == ({1'b0, $past(alu_a)} < {1'b0, $past(alu_b)} + $past(carry_out_flag)))
    else $error("borrow chain wrong");
  a_logic_clear: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && !arith |=> !carry_out_flag && !nibble_carry_flag)
    else $error("logic op left a carry");
  a_nibble_add: assert property (@(posedge clk) disable iff (!rst_n)
    alu_go && !status_load && alu_op == CFL_OP_ADD
    |=> nibble_carry_flag == ($past(alu_a[3:0]) + $past(alu_b[3:0]) > 5'h0f))
    else $error("nibble carry wrong");
  a_status_load: assert property (@(posedge clk) disable iff (!rst_n)
    status_load |=> processor_status_word == ($past(status_in) & 8'hd5 | 8'h02))
    else $error("status load wrong");
  a_result_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !alu_go || status_load || alu_op == CFL_OP_CMP |=> $stable(alu_result))
    else $error("result changed without update");

  // fixed bits of the packed status byte
  a_status_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    processor_status_word[FLAG_ONE_BIT] && !processor_status_word[FLAG_NIL3_BIT]
    && !processor_status_word[FLAG_NIL5_BIT])
    else $error("status byte constant bits wrong");
  a_io_port: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> io_port_addr == $past(port_byte))
    else $error("port address wrong");
  a_pc_load: assert property (@(posedge clk) disable iff (!rst_n)
    prog_counter_cmd == CFL_PTR_LOAD && !restart_go
    |=> {program_counter_high, program_counter_low} == $past(ptr_in))
    else $error("program counter load wrong");
  a_sp_low: assert property (@(posedge clk) disable iff (!rst_n)
    stack_ptr_cmd == CFL_PTR_LOAD_LO
    |=> stack_pointer_low == $past(ptr_in[DW-1:0]) && $stable(stack_pointer_high))
    else $error("stack pointer low byte wrong");
  a_dst_none: assert property (@(posedge clk) disable iff (!rst_n)
    dest_register_field == RSEL_M |=> dst_onehot == 8'h00)
    else $error("unused code selected a register");
  a_restart_vec: assert property (@(posedge clk) disable iff (!rst_n)
    restart_go |=> {program_counter_high, program_counter_low}
    == {10'h0, $past(restart_number_field), 3'h0})
    else $error("restart vector wrong");
  a_reg_decode: assert property (@(posedge clk) disable iff (!rst_n)
    source_register_field == RSEL_A |=> src_onehot == 8'h80)
    else $error("accumulator decode wrong");

  c_add_carry: cover property (@(posedge clk) alu_go && alu_op == CFL_OP_ADD ##1 carry_out_flag);
  c_sub_zero:  cover property (@(posedge clk) alu_go && alu_op == CFL_OP_SUB ##1 zero_flag);
  c_status_ld: cover property (@(posedge clk) status_load && alu_go);
  c_sbb_chain: cover property (@(posedge clk) alu_go && alu_op == CFL_OP_SBB && carry_out_flag);
  c_restart:   cover property (@(posedge clk) restart_go && restart_number_field == 3'h7);

endmodule : cfl_flag_unit

// file: verilog/cfl_pkg.sv
// package for the cpu condition flag and operand encoding block
// Operation
// - five one-bit flags: zero, sign, parity, carry, nibble carry; set=1, reset=0
// - flags an operation does not affect keep their previous values
// - zero flag set when result is 0, cleared otherwise
// - sign flag copies result most significant bit
// - parity flag set on even count of one bits
// - carry flag set on carry out of addition or borrow of subtraction
// - register field: 111 acc, 000 B, 001 C, 010 D, 011 E, 100 H, 101 L
// - program counter 16 bits, addressable as high and low bytes
// - stack pointer 16 bits, addressable as high and low bytes
// - restart number 0..7 coded as 000..111, target is eight times it
// - io instructions select a port by an 8-bit address from the instruction
// - subtraction is two's complement
// - status byte bits 7..0: sign, zero, 0, nibble carry, 0, parity, 1, carry
package cfl_pkg;
  localparam int DW = 8;
  localparam int AW = 16;
  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_ONE_BIT   = 1;
  localparam int FLAG_PAR_BIT   = 2;
  localparam int FLAG_NIL3_BIT  = 3;
  localparam int FLAG_NIB_BIT   = 4;
  localparam int FLAG_NIL5_BIT  = 5;
  localparam int FLAG_ZERO_BIT  = 6;
  localparam int FLAG_SIGN_BIT  = 7;
  localparam int NIB     = 4;
  localparam logic [2:0] RSEL_B = 3'h0;
  localparam logic [2:0] RSEL_C = 3'h1;
  localparam logic [2:0] RSEL_D = 3'h2;
  localparam logic [2:0] RSEL_E = 3'h3;
  localparam logic [2:0] RSEL_H = 3'h4;
  localparam logic [2:0] RSEL_L = 3'h5;
  localparam logic [2:0] RSEL_M = 3'h6;
  localparam logic [2:0] RSEL_A = 3'h7;
  localparam logic [2:0] RST_SHIFT = 3'h3;
  localparam logic [7:0] FLAGS_RST = 8'h02;
  typedef enum logic [2:0] {
    CFL_OP_ADD, CFL_OP_ADC, CFL_OP_SUB, CFL_OP_SBB,
    CFL_OP_AND, CFL_OP_XOR, CFL_OP_OR,  CFL_OP_CMP
  } cfl_op_t;
  typedef enum logic [1:0] {
    CFL_PTR_HOLD, CFL_PTR_LOAD_HI, CFL_PTR_LOAD_LO, CFL_PTR_LOAD
  } cfl_ptr_t;
endpackage : cfl_pkg
